// ---- common/sdct_pkg.sv ----
// package: command codes, timing constants and carriers for the sdram core
package sdct_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned MASK_W = 4;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned BANK_W = 2;
  localparam int unsigned ROW_W = 11;
  localparam int unsigned COL_W = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned MEM_W = BANK_W + COL_W;
  localparam logic [3:0] CMD_INHIBIT = 4'hF;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_STOP = 4'h6;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_MODE = 4'h0;
  localparam int unsigned MODE_LAT_LSB = 4;
  localparam logic [2:0] LAT_TWO = 3'h2;
  localparam logic [2:0] LAT_THREE = 3'h3;
  localparam logic [2:0] LAT_RESET = 3'h3;
  localparam logic [1:0] READ_MASK_FLOAT_DELAY = 2'h2;
  localparam logic [1:0] WRITE_MASK_DELAY = 2'h0;
  localparam logic [1:0] GATE_ON_DELAY = 2'h1;
  localparam int unsigned PIPE_LEN = 4;
  typedef struct packed {
    logic [3:0] code;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] addr;
  } sdct_cmd_type;
  typedef struct packed {
    logic valid;
    logic [MASK_W-1:0] mask;
    logic [DATA_W-1:0] data;
  } sdct_word_type;
endpackage : sdct_pkg

// ---- rtl/sdct_fifo.sv ----
// small valid/ready fifo for read data words
`timescale 1ns/1ps
module sdct_fifo import sdct_pkg::*; #(
  parameter int unsigned WIDTH = DATA_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  // full is compared at the counter's own width, so depth does not wrap
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  always_ff @(posedge mclk) begin
    if (push) mem_q[wr_q] <= in_data;
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sdct_fifo

// ---- rtl/sdct_core.sv ----
// sdram device core: command decode, masked writes, read pipe, float timing
//
// Operation
// - clock-gate low freezes device state one cycle later
// - clock-gate high resumes one cycle later; no command before then
// - write byte mask applies to same-cycle data, masked bytes kept
// - read byte mask floats those data bytes two cycles later
// - precharge during read floats outputs after read latency cycles
`timescale 1ns/1ps
module sdct_core import sdct_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_gate,
  input wire sdct_cmd_type cmd_in,
  input wire logic [MASK_W-1:0] byte_mask,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic [MASK_W-1:0] dq_oe,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [DATA_W-1:0] rd_data,
  output logic [2:0] read_latency_setting
);
  // ************************************************************
  // clock gate and command capture
  // ************************************************************
  // the gate acts one cycle after it is sampled
  logic gate_q;
  logic [2:0] lat_q;
  logic [MEM_W-1:0] col_q;
  logic burst_q;
  logic rd_act_q;
  logic [DATA_W-1:0] mem_q [2**MEM_W];
  wire run = gate_q;
  wire is_read = run && cmd_in.code == CMD_READ;
  wire is_write = run && cmd_in.code == CMD_WRITE;
  wire is_mode = run && cmd_in.code == CMD_MODE;
  wire is_pre = run && cmd_in.code == CMD_PRECHARGE;
  wire is_stop = run && cmd_in.code == CMD_STOP;
  wire [MEM_W-1:0] cmd_addr = {cmd_in.bank, cmd_in.addr[COL_W-1:0]};
  wire [MEM_W-1:0] wr_addr = is_write ? cmd_addr : col_q;
  // write data is taken in the command's own cycle
  wire wr_now = run && (is_write || (burst_q && !is_read && !is_pre
    && !is_stop && cmd_in.code != CMD_ACTIVE));
  wire [2:0] mode_lat = cmd_in.addr[MODE_LAT_LSB +: 3];
  wire lat_ok = mode_lat == LAT_TWO || mode_lat == LAT_THREE;
  wire [DATA_W-1:0] rd_word = mem_q[is_read ? cmd_addr : col_q];
  wire rd_now = run && (is_read || (!burst_q && rd_act_q && !is_pre
    && !is_stop && !is_write && cmd_in.code != CMD_ACTIVE));
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [MASK_W-1:0] msk
  );
    logic [DATA_W-1:0] r;
    r = old_w;
    for (int i = 0; i < MASK_W; i++) begin
      if (!msk[i]) r[i*BYTE_W +: BYTE_W] = new_w[i*BYTE_W +: BYTE_W];
    end
    return r;
  endfunction : merge
  always_ff @(posedge mclk) begin
    if (!rst_n) gate_q <= 1'b0;
    else gate_q <= clk_gate;
  end
  // masked bytes are left as stored, no delay on the mask
  always_ff @(posedge mclk) begin
    if (wr_now)
      mem_q[wr_addr] <= merge(mem_q[wr_addr], dq_in, byte_mask);
  end
  // ************************************************************
  // burst tracking and mode register
  // ************************************************************
  // column pointer advances every running cycle but holds on precharge or stop; a new column command each
  // cycle simply restarts the burst
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lat_q <= LAT_RESET;
      col_q <= '0;
      burst_q <= 1'b0;
      rd_act_q <= 1'b0;
    end else if (run) begin
      if (is_mode && lat_ok) lat_q <= mode_lat;
      if (is_write || is_read) begin
        col_q <= cmd_addr + MEM_W'(1);
        burst_q <= is_write;
        rd_act_q <= is_read;
      end else if (is_pre || is_stop) begin
        burst_q <= 1'b0;
        rd_act_q <= 1'b0;
      end else begin
        col_q <= col_q + MEM_W'(1);
      end
    end
  end
  // ************************************************************
  // read output pipe
  // ************************************************************
  // stage k holds data leaving k+1 cycles after the command; latency picks
  // the tap. a stopped or precharged burst drains out of the pipe, so its
  // float falls exactly latency cycles after the command
  sdct_word_type pipe_q [PIPE_LEN];
  logic [MASK_W-1:0] mpipe_q [PIPE_LEN];
  wire [1:0] tap = (lat_q == LAT_TWO) ? 2'h1 : 2'h2;
  wire sdct_word_type out_w = pipe_q[tap];
  // mask seen two cycles back selects floating lanes
  wire [MASK_W-1:0] float_mask = mpipe_q[READ_MASK_FLOAT_DELAY - 2'h1];
  genvar g;
  generate
    for (g = 1; g < PIPE_LEN; g++) begin : g_pipe
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          pipe_q[g] <= '0;
          mpipe_q[g] <= '0;
        end else if (run) begin
          pipe_q[g] <= pipe_q[g-1];
          mpipe_q[g] <= mpipe_q[g-1];
        end
      end
    end
  endgenerate
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pipe_q[0] <= '0;
      mpipe_q[0] <= '0;
    end else if (run) begin
      pipe_q[0] <= '{valid: rd_now, mask: '0, data: rd_word};
      mpipe_q[0] <= byte_mask;
    end
  end
  // ************************************************************
  // pins and read stream
  // ************************************************************
  wire [MASK_W-1:0] oe_d = out_w.valid ? ~float_mask : '0;
  logic fifo_in_ready;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dq_out <= '0;
      dq_oe <= '0;
      read_latency_setting <= LAT_RESET;
    end else begin
      dq_out <= out_w.data;
      dq_oe <= run ? oe_d : dq_oe; // frozen while gated
      read_latency_setting <= lat_q;
    end
  end
  // read words are copied into a local stream; if it backs up the copy is
  // dropped, the pins never stall
  logic cap_v_q;
  logic [DATA_W-1:0] cap_d_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cap_v_q <= 1'b0;
      cap_d_q <= '0;
    end else begin
      cap_v_q <= run && out_w.valid && fifo_in_ready;
      cap_d_q <= out_w.data;
    end
  end
  logic fo_v;
  logic [DATA_W-1:0] fo_d;
  sdct_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(cap_v_q),
    .in_ready(fifo_in_ready),
    .in_data(cap_d_q),
    .out_valid(fo_v),
    .out_ready(rd_ready && !rd_valid),
    .out_data(fo_d)
  );
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else if (rd_valid && rd_ready) begin
      rd_valid <= 1'b0;
    end else if (!rd_valid && fo_v && rd_ready) begin
      rd_valid <= 1'b1;
      rd_data <= fo_d;
    end
  end
endmodule : sdct_core

// ---- verif/sdct_core_properties.sv ----
// concurrent checks on the sdram core ports
`timescale 1ns/1ps
module sdct_core_properties import sdct_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_gate,
  input wire sdct_cmd_type cmd_in,
  input wire logic [MASK_W-1:0] byte_mask,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic [MASK_W-1:0] dq_oe,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic [2:0] read_latency_setting
);
  // ****************
  // helper logic
  // ****************
  logic gate_q;
  logic [2:0] lat_req;
  logic pre_taken;
  logic lat_ok;
  assign lat_req = cmd_in.addr[MODE_LAT_LSB+2:MODE_LAT_LSB];
  assign lat_ok = lat_req == LAT_TWO || lat_req == LAT_THREE;
  assign pre_taken = gate_q && cmd_in.code == CMD_PRECHARGE;
  always_ff @(posedge mclk) begin
    if (!rst_n) gate_q <= 1'b0;
    else gate_q <= clk_gate;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_read_open;
    gate_q && cmd_in.code == CMD_READ && read_latency_setting == LAT_THREE;
  endsequence
  sequence s_mask_clear;
    byte_mask == 4'h0 [*3];
  endsequence
  a_read_drives:
    assert property (s_read_open ##0 s_mask_clear |=> ##1 dq_oe == 4'hF)
    else $error("read word not driven at latency three");
  a_mask_float:
    assert property (dq_oe != 4'h0 |-> dq_oe == ~$past(byte_mask, 3))
    else $error("output enable does not follow read mask");
  a_prech_three:
    assert property (pre_taken && read_latency_setting == LAT_THREE
      |-> ##4 dq_oe == 4'h0) else $error("no float after precharge");
  a_prech_two:
    assert property (pre_taken && read_latency_setting == LAT_TWO
      |-> ##3 dq_oe == 4'h0) else $error("no float after precharge");
  a_gated_hold:
    assert property (!gate_q |=> $stable(read_latency_setting))
    else $error("gated command changed latency");
  a_mode_take:
    assert property (gate_q && cmd_in.code == CMD_MODE && lat_ok
      |=> ##1 read_latency_setting == $past(lat_req, 2))
    else $error("mode load not applied");
  a_stream_hold:
    assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("stream word dropped while stalled");
  a_reset_clear:
    assert property ($rose(rst_n) |-> dq_oe == 4'h0 && !rd_valid)
    else $error("outputs active out of reset");
endmodule : sdct_core_properties

bind sdct_core sdct_core_properties u_sdct_core_properties (.mclk(mclk),
  .rst_n(rst_n), .clk_gate(clk_gate), .cmd_in(cmd_in),
  .byte_mask(byte_mask), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
  .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
  .read_latency_setting(read_latency_setting));

// ---- verif/sdct_ctl.sv ----
// memory controller model driving commands, masks, data and clock gate
`timescale 1ns/1ps
module sdct_ctl import sdct_pkg::*; #(
  parameter int unsigned INIT_WAIT = 25000
) (
  input wire logic mclk,
  output logic clk_gate,
  output sdct_cmd_type cmd_in,
  output logic [MASK_W-1:0] byte_mask,
  output logic [DATA_W-1:0] dq_in
);
  // ****************
  // command driver
  // ****************
  logic [3:0] last_q = CMD_NOP;
  // bank of the next command, set by the scenario
  logic [1:0] bank_sel = 2'h0;
  initial begin
    clk_gate = 1'b0;
    cmd_in = '{CMD_NOP, 2'h0, 11'h000};
    byte_mask = 4'h0;
    dq_in = 32'h0;
  end
  // released data lines toggle so stale data never looks valid
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge mclk);
      cmd_in.code = CMD_NOP;
      dq_in = ~dq_in;
    end
  endtask : idle
  task automatic issue(input logic [3:0] c, input logic [10:0] a,
      input logic [31:0] d, input logic [3:0] m);
    if (last_q == CMD_MODE) idle(2);
    if (last_q == CMD_WRITE && c != CMD_WRITE && c != CMD_READ) idle(2);
    @(negedge mclk);
    cmd_in = '{c, bank_sel, a};
    dq_in = d;
    byte_mask = m;
    last_q = c;
  endtask : issue
  task automatic set_gate(input logic g);
    @(negedge mclk);
    clk_gate = g;
    cmd_in.code = CMD_NOP;
    idle(1);
  endtask : set_gate
  task automatic wake();
    idle(INIT_WAIT);
    repeat (2) issue(CMD_REFRESH, 11'h0, 32'h0, 4'h0);
  endtask : wake
endmodule : sdct_ctl

// ---- verif/testbench.sv ----
// self-checking bench for the sdram core
`timescale 1ns/1ps
module testbench import sdct_pkg::*;;
  // ****************
  // harness
  // ****************
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic rd_ready = 1'b1;
  logic clk_gate, rd_valid;
  sdct_cmd_type cmd_in;
  logic [MASK_W-1:0] byte_mask, dq_oe;
  logic [DATA_W-1:0] dq_in, dq_out, rd_data;
  logic [2:0] read_latency_setting;
  int err_count = 0;
  int comparisons = 0;
  always #2 mclk = ~mclk;
  sdct_core u_sdct_core (.mclk(mclk), .rst_n(rst_n), .clk_gate(clk_gate),
    .cmd_in(cmd_in), .byte_mask(byte_mask), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .read_latency_setting(read_latency_setting));
  sdct_ctl u_sdct_ctl (.mclk(mclk), .clk_gate(clk_gate), .cmd_in(cmd_in),
    .byte_mask(byte_mask), .dq_in(dq_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  task automatic rd_chk(input logic [10:0] a, input logic [3:0] m,
      input logic [31:0] e, input int lat);
    logic [3:0] oe;
    logic [31:0] bm;
    oe = ~m;
    bm = {{8{oe[3]}}, {8{oe[2]}}, {8{oe[1]}}, {8{oe[0]}}};
    u_sdct_ctl.issue(CMD_READ, a, 32'h0, m);
    u_sdct_ctl.idle(1);
    repeat (lat) @(posedge mclk);
    #1;
    chk(dq_oe, oe);
    chk(dq_out & bm, e & bm);
    u_sdct_ctl.issue(CMD_STOP, 11'h0, 32'h0, 4'h0);
    u_sdct_ctl.idle(6);
  endtask : rd_chk
  task automatic t_prech(input int lat);
    u_sdct_ctl.issue(CMD_READ, 11'h0, 32'h0, 4'h0);
    u_sdct_ctl.issue(CMD_PRECHARGE, 11'h0, 32'h0, 4'h0);
    repeat (lat) @(posedge mclk);
    #1;
    chk(dq_oe, 4'hF);
    @(posedge mclk);
    #1;
    chk(dq_oe, 4'h0);
    u_sdct_ctl.idle(6);
  endtask : t_prech
  task automatic t_write();
    u_sdct_ctl.issue(CMD_WRITE, 11'h0, 32'h11223344, 4'h0);
    u_sdct_ctl.issue(CMD_WRITE, 11'h0, 32'hAABBCCDD, 4'h5);
    rd_chk(11'h0, 4'h0, 32'hAA22CC44, 3);
    u_sdct_ctl.bank_sel = 2'h2;
    u_sdct_ctl.issue(CMD_WRITE, 11'h0, 32'h0F1E2D3C, 4'h0);
    rd_chk(11'h0, 4'h0, 32'h0F1E2D3C, 3);
    u_sdct_ctl.bank_sel = 2'h0;
  endtask : t_write
  task automatic t_mode();
    u_sdct_ctl.issue(CMD_MODE, 11'h020, 32'h0, 4'h0);
    u_sdct_ctl.idle(2);
    chk(read_latency_setting, LAT_TWO);
    u_sdct_ctl.issue(CMD_MODE, 11'h050, 32'h0, 4'h0);
    u_sdct_ctl.idle(2);
    chk(read_latency_setting, LAT_TWO);
    rd_chk(11'h0, 4'h3, 32'hAA22CC44, 2);
    t_prech(2);
    u_sdct_ctl.issue(CMD_MODE, 11'h030, 32'h0, 4'h0);
    u_sdct_ctl.idle(2);
    chk(read_latency_setting, LAT_THREE);
  endtask : t_mode
  task automatic t_gate();
    u_sdct_ctl.set_gate(1'b0);
    u_sdct_ctl.issue(CMD_WRITE, 11'h0, 32'h5A5A5A5A, 4'h0);
    u_sdct_ctl.set_gate(1'b1);
    rd_chk(11'h0, 4'h0, 32'hAA22CC44, 3);
  endtask : t_gate
  task automatic t_fifo();
    int n;
    n = 0;
    // let words left from earlier reads drain before the stall
    u_sdct_ctl.idle(20);
    rd_ready = 1'b0;
    u_sdct_ctl.issue(CMD_READ, 11'h0, 32'h0, 4'h0);
    u_sdct_ctl.idle(14);
    u_sdct_ctl.issue(CMD_STOP, 11'h0, 32'h0, 4'h0);
    u_sdct_ctl.idle(8);
    for (int i = 0; i < 40; i++) begin
      @(negedge mclk);
      if (rd_valid === 1'b1) begin
        if (n == 0) chk(rd_data, 32'hAA22CC44);
        n++;
      end
      rd_ready = 1'b1;
    end
    chk(n, FIFO_DEPTH);
  endtask : t_fifo
  initial begin
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    chk(dq_oe, 4'h0);
    chk(rd_valid, 1'b0);
    chk(read_latency_setting, LAT_RESET);
    u_sdct_ctl.set_gate(1'b1);
    u_sdct_ctl.wake();
    t_write();
    t_prech(3);
    t_mode();
    t_prech(3);
    t_gate();
    t_fifo();
    complete_run();
  end
endmodule : testbench
